// >>> dv/mcb_bus_glue_tb.sv
// Self-checking bench for the bus glue block
`timescale 1ns/1ps
module mcb_bus_glue_tb;
    import mcb_pkg::*;
    localparam logic [7:0] BUF_A = 8'h3c;
    localparam logic [7:0] BUF_B = 8'hc5;
    localparam logic [7:0] FRQ = 8'h96;
    typedef struct {
        mcb_kind_t k;
        logic chk;
        logic [39:0] exp;
    } mcb_note_t;
    mcb_note_t notes[$]; // Expected results, oldest first
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] rng = 32'h9a1d; // Xorshift state
    logic [15:0] cur_addr = 16'h0000; // Address of the access in flight
    logic [7:0] cur_data = 8'h00;
    mcb_kind_t cur_kind = MCB_READ;
    logic [39:0] shadow; // Expected output latch contents
    logic lat_ok = 1'b0; // Shadow fully known
    logic run = 1'b0; // Port monitors active
    logic [4:0] snap; // Port controls at the last edge
    logic [7:0] hi_tbl [14] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h00, 8'h01,
        8'h02, 8'h03, 8'h04, 8'h08, 8'h45, 8'h46, 8'h48};
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_req = 1'b0;
    mcb_kind_t i_kind = MCB_READ;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00;
    logic o_ready, o_ack, o_muxed_data_bus_oe, o_address_latch_strobe;
    logic o_program_fetch_strobe_n, o_read_strobe_n, o_write_strobe_n;
    logic [7:0] o_rdata, bus_in, o_muxed_data_bus_out;
    logic [15:0] o_address;
    logic o_select_input_buffer_a_n, o_select_input_buffer_b_n, o_select_freq_reader_n;
    logic [4:0] o_select_output_latch_n;
    logic [39:0] latch_bus;
    logic [4:0] ctl = 5'h00; // Normal, sensor, aux enable, bypass, link request
    logic [2:0] pin = 3'h0; // Byte flag, end pulse, transmit key
    logic i_watchdog_kick = 1'b0;
    logic [5:0] port_out;
    logic [2:0] pin_out;

    // 50 MHz clock
    always #10 i_clk = ~i_clk;

    mcb_bus_glue dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .i_kind(i_kind),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_ack(o_ack),
        .o_rdata(o_rdata), .i_muxed_data_bus_in(bus_in),
        .o_muxed_data_bus_out(o_muxed_data_bus_out), .o_muxed_data_bus_oe(o_muxed_data_bus_oe),
        .o_address_latch_strobe(o_address_latch_strobe),
        .o_program_fetch_strobe_n(o_program_fetch_strobe_n),
        .o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n),
        .o_address(o_address), .o_select_input_buffer_a_n(o_select_input_buffer_a_n),
        .o_select_input_buffer_b_n(o_select_input_buffer_b_n),
        .o_select_freq_reader_n(o_select_freq_reader_n),
        .o_select_output_latch_n(o_select_output_latch_n), .i_normal_path(ctl[4]),
        .i_sensor_path(ctl[3]), .i_aux_input_enable(ctl[2]), .i_first_bypass(ctl[1]),
        .i_link_request(ctl[0]), .i_watchdog_kick(i_watchdog_kick),
        .o_normal_path_select(port_out[4]), .o_sensor_path_enable(port_out[3]),
        .o_auxiliary_input_gate_n(port_out[2]), .o_first_bypass_select(port_out[1]),
        .o_link_request_n(port_out[0]), .o_watchdog_clear_pulse(port_out[5]),
        .i_freq_byte_flag(pin[2]), .i_freq_data_end_pulse(pin[1]),
        .i_transmit_key_in(pin[0]), .o_freq_byte_flag(pin_out[2]),
        .o_freq_data_end_pulse(pin_out[1]), .o_transmit_key(pin_out[0]));

    mcb_far_model #(.BUF_A(BUF_A), .BUF_B(BUF_B), .FRQ(FRQ)) far_u (.i_clk(i_clk),
        .i_program_fetch_strobe_n_n(o_program_fetch_strobe_n), .i_rd_n(o_read_strobe_n), .i_address(o_address),
        .i_bus_out(o_muxed_data_bus_out), .i_oe(o_muxed_data_bus_oe),
        .i_sel_a_n(o_select_input_buffer_a_n), .i_sel_b_n(o_select_input_buffer_b_n),
        .i_sel_f_n(o_select_freq_reader_n), .i_lat_n(o_select_output_latch_n),
        .o_bus_in(bus_in), .o_latch(latch_bus));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // One bus access; the expected result goes on the queue first
    task automatic access(input mcb_kind_t k, input logic [15:0] a, input logic [7:0] d);
        mcb_note_t nt;
        int n;
        nt.k = k;
        nt.chk = lat_ok;
        if (k == MCB_FETCH) begin
            nt.chk = 1'b1;
            nt.exp = 40'(a[7:0] ^ a[15:8] ^ 8'h5a);
        end else if (k == MCB_READ) begin
            nt.chk = a[15:8] < 8'h03;
            nt.exp = 40'(a[8] ? BUF_B : a[9] ? FRQ : BUF_A);
        end else begin
            if (a[15:8] >= 8'h40 && a[15:8] <= 8'h44) begin
                shadow[8*a[10:8] +: 8] = d;
            end
            nt.exp = shadow;
        end
        notes.push_back(nt);
        cur_addr = a;
        cur_data = d;
        cur_kind = k;
        i_req = 1'b1;
        i_kind = k;
        i_addr = a;
        i_wdata = d;
        while (o_ready !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
        i_req = 1'b0;
        check(40'({o_address_latch_strobe, o_ready}), 40'h2);
        n = 1;
        while (o_ack !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        check(40'(n), 40'd13);
    endtask : access

    // Latch the port controls as the design sees them
    always @(posedge i_clk) begin
        snap <= {ctl[4:3], ~ctl[2], ctl[1], ~ctl[0]};
    end

    // Watcher: results, selects, strobes and port lines
    always @(negedge i_clk) begin
        mcb_note_t nt;
        logic [7:0] sx;
        logic [7:0] hi;
        hi = cur_addr[15:8];
        if (run) begin
            if (o_ack === 1'b1 && notes.size() > 0) begin
                nt = notes.pop_front();
                if (nt.chk && nt.k == MCB_WRITE) check(latch_bus, nt.exp);
                if (nt.chk && nt.k != MCB_WRITE) check(40'(o_rdata), nt.exp);
            end
            sx = 8'hff;
            if (o_read_strobe_n === 1'b0 && hi < 8'h03) sx[7 - hi[1:0]] = 1'b0;
            if (o_write_strobe_n === 1'b0 && hi >= 8'h40 && hi <= 8'h44) sx[hi[2:0]] = 1'b0;
            check(40'({o_select_input_buffer_a_n, o_select_input_buffer_b_n,
                o_select_freq_reader_n, o_select_output_latch_n}), 40'(sx));
            if ({o_read_strobe_n, o_write_strobe_n, o_program_fetch_strobe_n} !== 3'b111) begin
                check(40'(o_address), 40'(cur_addr));
                check(40'({o_read_strobe_n, o_write_strobe_n, o_program_fetch_strobe_n}),
                    40'({cur_kind != MCB_READ, cur_kind != MCB_WRITE, cur_kind != MCB_FETCH}));
            end
            if (o_read_strobe_n === 1'b0) check(40'(o_muxed_data_bus_oe), 40'd0);
            if (o_write_strobe_n === 1'b0) check(40'({o_muxed_data_bus_oe, o_muxed_data_bus_out}), 40'({1'b1, cur_data}));
            check(40'(port_out[4:0]), 40'(snap));
            rng = xs(rng);
            ctl = rng[4:0];
        end
    end

    // Main sequence
    initial begin
        int hits;
        repeat (12) @(negedge i_clk);
        i_srst = 1'b0;
        @(negedge i_clk);
        run = 1'b1;
        // Every mapped high byte, plus two spare and one unused high byte per decoder, each with its natural strobe
        foreach (hi_tbl[i]) begin
            access(hi_tbl[i][6] ? MCB_WRITE : MCB_READ, {hi_tbl[i], rng[7:0]}, rng[15:8]);
            if (i == 4) lat_ok = 1'b1;
        end
        // Random kinds against random targets, fetches anywhere
        repeat (60) begin
            rng = xs(rng);
            access(mcb_kind_t'(rng[1:0] % 2'd3), rng[1:0] == 2'd0 ? rng[27:12] :
                {hi_tbl[rng[11:8] % 4'd14], rng[23:16]}, rng[31:24]);
        end
        // Reader and transceiver pins: levels follow, end pulse once
        hits = 0;
        pin = 3'b111;
        repeat (10) begin
            @(negedge i_clk);
            hits += int'(pin_out[1]);
        end
        check(40'(hits), 40'd1);
        check(40'({pin_out[2], pin_out[0]}), 40'h3);
        pin = 3'b000;
        repeat (6) @(negedge i_clk);
        check(40'({pin_out[2], pin_out[0]}), 40'h0);
        // Watchdog: a second kick during the pulse must not stretch it
        hits = 0;
        i_watchdog_kick = 1'b1;
        repeat (14) begin
            @(negedge i_clk);
            if (hits == 1) i_watchdog_kick = 1'b0;
            hits += int'(port_out[5]);
        end
        check(40'(hits), 40'd10);
        final_report();
    end

    // Hang guard, well beyond the expected run
    initial begin
        #(20 * 6000);
        err_total++;
        $display("mismatch at %0t ns: run did not finish", $time);
        final_report();
    end
endmodule : mcb_bus_glue_tb

// >>> dv/mcb_far_model.sv
// Far side model: program memory, input buffers, reader and output latches
`timescale 1ns/1ps
module mcb_far_model #(
    parameter logic [7:0] BUF_A = 8'h00, // Level seen by input buffer a
    parameter logic [7:0] BUF_B = 8'h00, // Level seen by input buffer b
    parameter logic [7:0] FRQ = 8'h00 // Byte held by the reader
) (
    input wire logic i_clk,
    input wire logic i_program_fetch_strobe_n_n,
    input wire logic i_rd_n,
    input wire logic [15:0] i_address,
    input wire logic [7:0] i_bus_out,
    input wire logic i_oe,
    input wire logic i_sel_a_n,
    input wire logic i_sel_b_n,
    input wire logic i_sel_f_n,
    input wire logic [4:0] i_lat_n,
    output logic [7:0] o_bus_in,
    output logic [39:0] o_latch
);
    logic [7:0] last_q = 8'h00; // Last level, flipped when nobody drives
    logic [7:0] lat_q [5]; // Output latch contents

    // One driver at a time; a released bus must not look like stale data
    always @(*) begin
        if (i_oe) begin
            o_bus_in = i_bus_out;
        end else if (!i_program_fetch_strobe_n_n) begin
            o_bus_in = i_address[7:0] ^ i_address[15:8] ^ 8'h5a;
        end else if (!i_rd_n && !i_sel_a_n) begin
            o_bus_in = BUF_A;
        end else if (!i_rd_n && !i_sel_b_n) begin
            o_bus_in = BUF_B;
        end else if (!i_rd_n && !i_sel_f_n) begin
            o_bus_in = FRQ;
        end else begin
            o_bus_in = ~last_q;
        end
    end

    // Remember the level for the floating pattern
    always @(posedge i_clk) begin
        last_q <= o_bus_in;
    end

    // Each latch takes the bus byte as its own select rises
    for (genvar k = 0; k < 5; k++) begin : g_lat
        always @(posedge i_lat_n[k]) begin
            lat_q[k] <= i_bus_out;
        end
        assign o_latch[8*k +: 8] = lat_q[k];
    end
endmodule : mcb_far_model

// >>> logic/mcb_bus_glue.sv
// Multiplexed bus sequencer, address latch, chip selects and port lines
`timescale 1ns/1ps
module mcb_bus_glue (
    input wire logic i_clk,
    input wire logic i_srst,
    // User request side
    input wire logic i_req,
    input wire mcb_pkg::mcb_kind_t i_kind,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_ready,
    output logic o_ack,
    output logic [7:0] o_rdata,
    // Multiplexed bus and strobes
    input wire logic [7:0] i_muxed_data_bus_in,
    output logic [7:0] o_muxed_data_bus_out,
    output logic o_muxed_data_bus_oe,
    output logic o_address_latch_strobe,
    output logic o_program_fetch_strobe_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic [15:0] o_address,
    // Chip selects
    output logic o_select_input_buffer_a_n,
    output logic o_select_input_buffer_b_n,
    output logic o_select_freq_reader_n,
    output logic [4:0] o_select_output_latch_n,
    // Port line controls
    input wire logic i_normal_path,
    input wire logic i_sensor_path,
    input wire logic i_aux_input_enable,
    input wire logic i_first_bypass,
    input wire logic i_link_request,
    input wire logic i_watchdog_kick,
    output logic o_normal_path_select,
    output logic o_sensor_path_enable,
    output logic o_auxiliary_input_gate_n,
    output logic o_first_bypass_select,
    output logic o_link_request_n,
    output logic o_watchdog_clear_pulse,
    // Port line inputs from the reader and transceiver
    input wire logic i_freq_byte_flag,
    input wire logic i_freq_data_end_pulse,
    input wire logic i_transmit_key_in,
    output logic o_freq_byte_flag,
    output logic o_freq_data_end_pulse,
    output logic o_transmit_key
);
    import mcb_pkg::*;

    // Phases of one bus access
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_HOLD,
        ST_STROBE,
        ST_DONE
    } mcb_state_t;

    // Whole state of the block
    typedef struct packed {
        mcb_state_t st; // Bus phase
        mcb_kind_t kind; // Access being run
        logic [CNT_W-1:0] cnt; // Phase length counter
        logic ale; // Address latch strobe
        logic program_fetch_strobe_n_n; // Fetch strobe
        logic rd_n; // Read strobe
        logic wr_n; // Write strobe
        logic [7:0] hi; // High address byte
        logic [7:0] lat; // Low address latch contents
        logic [7:0] dout; // Bus drive value
        logic oe; // Bus drive enable
        logic [7:0] wdata; // Held write data
        logic [7:0] rdata; // Captured read data
        logic ack; // Access finished
        logic [CNT_W-1:0] wd_cnt; // Watchdog pulse length
        logic wd; // Watchdog clear line
        logic link_n; // Link request line
        logic normal; // Normal path line
        logic sensor; // Sensor path line
        logic aux_n; // Auxiliary gate line
        logic bypass; // Bypass switch line
        logic end_prev; // Last end-of-data level
        logic end_pulse; // End-of-data pulse out
    } mcb_glue_t;

    mcb_glue_t q;
    mcb_glue_t d;
    logic [10:0] pins_lvl; // Synchronised pin levels
    logic upper_nz; // A11..A13 non-zero: unused range

    mcb_sel_if sel_if ();

    // Address and strobes feed the decoders
    assign sel_if.addr_hi = q.hi;
    assign sel_if.rd_n = q.rd_n;
    assign sel_if.wr_n = q.wr_n;

    mcb_select_decode u_decode (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .sel(sel_if.dec)
    );

    // Pins and the bus come from outside, so all pass the synchroniser
    mcb_pin_sync #(
        .W(11)
    ) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_pin({i_freq_byte_flag, i_freq_data_end_pulse, i_transmit_key_in,
            i_muxed_data_bus_in}),
        .o_level(pins_lvl)
    );

    // Next state
    always_comb begin
        d = q;
        d.ack = 1'b0;
        // Port lines follow the user controls one cycle later
        d.normal = i_normal_path;
        d.sensor = i_sensor_path;
        d.aux_n = ~i_aux_input_enable;
        d.bypass = i_first_bypass;
        d.link_n = ~i_link_request;
        // Reader end-of-data turned into a one-cycle pulse
        d.end_prev = pins_lvl[9];
        d.end_pulse = pins_lvl[9] && !q.end_prev;
        // Watchdog clear: a kick starts a fixed-width pulse, kicks inside it are ignored
        if (q.wd_cnt != '0) begin
            d.wd_cnt = q.wd_cnt - CNT_W'(1);
        end else if (i_watchdog_kick) begin
            d.wd_cnt = CNT_W'(WD_PULSE_CYC);
        end
        d.wd = (d.wd_cnt != '0);
        case (q.st)
            ST_IDLE: begin
                if (i_req) begin
                    // Address goes out with the latch strobe; latch and high byte load now
                    d.st = ST_ADDR;
                    d.kind = i_kind;
                    d.hi = i_addr[15:8];
                    d.lat = i_addr[7:0];
                    d.dout = i_addr[7:0];
                    d.oe = 1'b1;
                    d.ale = 1'b1;
                    d.wdata = i_wdata;
                    d.cnt = CNT_W'(ALE_CYC - 1);
                end
            end
            ST_ADDR: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - CNT_W'(1);
                end else begin
                    // One cycle of address hold after the strobe falls
                    d.ale = 1'b0;
                    d.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                d.st = ST_STROBE;
                d.cnt = CNT_W'(STROBE_CYC - 1);
                case (q.kind)
                    MCB_FETCH: begin
                        d.program_fetch_strobe_n_n = 1'b0;
                        d.oe = 1'b0;
                    end
                    MCB_READ: begin
                        d.rd_n = 1'b0;
                        d.oe = 1'b0;
                    end
                    MCB_WRITE: begin
                        d.wr_n = 1'b0;
                        d.dout = q.wdata;
                    end
                    default: begin
                        d.st = ST_DONE;
                    end
                endcase
            end
            ST_STROBE: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - CNT_W'(1);
                end else begin
                    // Strobes rise together; read data is taken just before
                    d.program_fetch_strobe_n_n = STROBE_RST_N;
                    d.rd_n = STROBE_RST_N;
                    d.wr_n = STROBE_RST_N;
                    if (q.kind != MCB_WRITE) begin
                        d.rdata = pins_lvl[7:0];
                    end
                    d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // Write data held one more cycle so latches see it at the select edge
                d.oe = 1'b0;
                d.ack = 1'b1;
                d.st = ST_IDLE;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        if (i_srst) begin
            d = '0;
            d.st = ST_IDLE;
            d.program_fetch_strobe_n_n = STROBE_RST_N;
            d.rd_n = STROBE_RST_N;
            d.wr_n = STROBE_RST_N;
            d.link_n = LINK_REQ_RST_N;
            d.aux_n = AUX_GATE_RST_N;
            d.normal = PATH_RST;
            d.sensor = PATH_RST;
            d.bypass = PATH_RST;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        q <= d;
    end

    // Spare block bits: accesses there must not select anything
    assign upper_nz = |q.hi[UNUSED_MSB:UNUSED_LSB];

    // Only mapped selects reach the pins; spare decoder outputs stay unused
    always_comb begin
        o_select_input_buffer_a_n = sel_if.rd_y_n[0] | upper_nz;
        o_select_input_buffer_b_n = sel_if.rd_y_n[1] | upper_nz;
        o_select_freq_reader_n = sel_if.rd_y_n[RD_TARGETS-1] | upper_nz;
        o_select_output_latch_n = sel_if.wr_y_n[WR_TARGETS-1:0] | {5{upper_nz}};
    end

    // Outputs
    assign o_ready = (q.st == ST_IDLE);
    assign o_ack = q.ack;
    assign o_rdata = q.rdata;
    assign o_muxed_data_bus_out = q.dout;
    assign o_muxed_data_bus_oe = q.oe;
    assign o_address_latch_strobe = q.ale;
    assign o_program_fetch_strobe_n = q.program_fetch_strobe_n_n;
    assign o_read_strobe_n = q.rd_n;
    assign o_write_strobe_n = q.wr_n;
    assign o_address = {q.hi, q.lat};
    assign o_normal_path_select = q.normal;
    assign o_sensor_path_enable = q.sensor;
    assign o_auxiliary_input_gate_n = q.aux_n;
    assign o_first_bypass_select = q.bypass;
    assign o_link_request_n = q.link_n;
    assign o_watchdog_clear_pulse = q.wd;
    assign o_freq_byte_flag = pins_lvl[10];
    assign o_freq_data_end_pulse = q.end_pulse;
    assign o_transmit_key = pins_lvl[8];

    // Read strobe stays low exactly the strobe length
    a_rd_strobe_len: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_read_strobe_n) |-> (!o_read_strobe_n) [*8] ##1 o_read_strobe_n)
        else $error("read strobe width wrong");
    // Write strobe width, data driven through and one cycle past it
    a_wr_strobe_len: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(o_write_strobe_n) |-> (!o_write_strobe_n && o_muxed_data_bus_oe) [*8]
        ##1 (o_write_strobe_n && o_muxed_data_bus_oe))
        else $error("write strobe or data hold wrong");
    // Latch holds the byte on the bus when the latch strobe rises
    a_ale_latch_load: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(o_address_latch_strobe) |->
        (o_address[7:0] == o_muxed_data_bus_out && o_muxed_data_bus_oe))
        else $error("low address latch mismatch");
    // Bus released while read or fetch strobe low
    a_bus_read_release: assert property (@(posedge i_clk) disable iff (i_srst)
        (!o_read_strobe_n || !o_program_fetch_strobe_n) |-> !o_muxed_data_bus_oe)
        else $error("bus driven during read");
    // Address stable from latch strobe to access end
    a_addr_hi_stable: assert property (@(posedge i_clk) disable iff (i_srst)
        (!o_ready && !$past(o_ready)) |-> $stable(o_address))
        else $error("address changed inside an access");
    // At most one strobe low at a time
    a_strobe_excl: assert property (@(posedge i_clk) disable iff (i_srst)
        $onehot0({!o_read_strobe_n, !o_write_strobe_n, !o_program_fetch_strobe_n}))
        else $error("two strobes low together");
    // Kick from idle gives a ten-cycle clearing pulse
    a_wd_pulse_len: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_watchdog_kick && !o_watchdog_clear_pulse) |=> o_watchdog_clear_pulse [*8]
        ##1 o_watchdog_clear_pulse ##1 o_watchdog_clear_pulse ##1 !o_watchdog_clear_pulse)
        else $error("watchdog pulse width wrong");
    // Link request is the inverse of the user control, one cycle on
    a_link_req_low: assert property (@(posedge i_clk) disable iff (i_srst)
        !$past(i_srst) |-> (o_link_request_n == !$past(i_link_request)))
        else $error("link request level wrong");
    // Unused upper address bits block every select
    a_unused_no_sel: assert property (@(posedge i_clk) disable iff (i_srst)
        (|o_address[13:11]) |-> (o_select_input_buffer_a_n && o_select_input_buffer_b_n
        && o_select_freq_reader_n && &o_select_output_latch_n))
        else $error("select asserted in unused range");
endmodule : mcb_bus_glue

// >>> logic/mcb_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module mcb_pin_sync #(
    parameter int W = 11
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);
    import mcb_pkg::*;

    // Whole state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1; // First stage, read only by s2
        logic [W-1:0] s2; // Second stage
        logic [W-1:0] s3; // Third stage
        logic [W-1:0] lvl; // Accepted level
    } mcb_sync_t;

    mcb_sync_t sync_q;
    mcb_sync_t sync_d;

    // Next state: a bit changes only once stages two and three agree
    always_comb begin
        sync_d = sync_q;
        sync_d.s1 = i_pin;
        sync_d.s2 = sync_q.s1;
        sync_d.s3 = sync_q.s2;
        for (int i = 0; i < W; i++) begin
            if (sync_q.s2[i] == sync_q.s3[i]) begin
                sync_d.lvl[i] = sync_q.s3[i];
            end
        end
        if (i_srst) begin
            sync_d = '0;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        sync_q <= sync_d;
    end

    assign o_level = sync_q.lvl;

    // Accepted level only moves to a value both late stages held; checked per bit,
    // since a bit still bouncing keeps its old level while its neighbours move
    a_sync_agree: assert property (@(posedge i_clk) disable iff (i_srst)
        !$stable(o_level) |->
        (((o_level ^ $past(o_level)) & (o_level ^ $past(sync_q.s3))) == '0))
        else $error("synchroniser accepted an unsettled level");
endmodule : mcb_pin_sync

// >>> logic/mcb_pkg.sv
// Shared constants, types and decode function for the bus glue block
package mcb_pkg;
    // Clock period of i_clk
    localparam int CLK_NS = 20;
    // Least address latch strobe width and least read/write/fetch strobe width
    localparam int ALE_NS = 40;
    localparam int STROBE_NS = 160;
    // Least width of a watchdog clearing pulse
    localparam int WD_PULSE_NS = 200;
    // Least times round up to whole cycles
    localparam int ALE_CYC = (ALE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WD_PULSE_CYC = (WD_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // Width of the phase counters
    localparam int CNT_W = 4;

    // High address bytes of the mapped targets
    localparam logic [7:0] RD_BASE_HI = 8'h00;
    localparam int RD_TARGETS = 3;
    localparam logic [7:0] WR_BASE_HI = 8'h40;
    localparam int WR_TARGETS = 5;
    // Field positions inside the high address byte
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 2;
    localparam int UNUSED_LSB = 3;
    localparam int UNUSED_MSB = 5;
    localparam int A14_BIT = 6;
    localparam int A15_BIT = 7;

    // Reset values of the strobes and port lines
    localparam logic STROBE_RST_N = 1'b1;
    localparam logic LINK_REQ_RST_N = 1'b1;
    localparam logic AUX_GATE_RST_N = 1'b1;
    localparam logic PATH_RST = 1'b0;
    localparam logic [7:0] SEL_IDLE_N = 8'hff;

    // Kind of bus access requested by the user side
    typedef enum logic [1:0] {
        MCB_FETCH,
        MCB_READ,
        MCB_WRITE
    } mcb_kind_t;

    // Three-to-eight active-low decode, all high while disabled
    function automatic logic [7:0] mcb_decode_n(input logic en, input logic [2:0] sel);
        logic [7:0] y;
        y = SEL_IDLE_N;
        if (en) begin
            y = ~(8'h01 << sel);
        end
        return y;
    endfunction : mcb_decode_n
endpackage : mcb_pkg

// >>> logic/mcb_sel_if.sv
// Carrier between the bus sequencer and the select decoders
`timescale 1ns/1ps
interface mcb_sel_if;
    logic [7:0] addr_hi; // High address byte on the second port
    logic rd_n; // Read strobe, active low
    logic wr_n; // Write strobe, active low
    logic [7:0] rd_y_n; // Read decoder outputs, active low
    logic [7:0] wr_y_n; // Write decoder outputs, active low

    // Sequencer drives address and strobes
    modport ctrl (output addr_hi, output rd_n, output wr_n, input rd_y_n, input wr_y_n);
    // Decoders see address and strobes
    modport dec (input addr_hi, input rd_n, input wr_n, output rd_y_n, output wr_y_n);
endinterface : mcb_sel_if

// >>> logic/mcb_select_decode.sv
// Read and write chip-select decoders
`timescale 1ns/1ps
module mcb_select_decode (
    input wire logic i_clk,
    input wire logic i_srst,
    mcb_sel_if.dec sel
);
    import mcb_pkg::*;

    logic rd_en; // Read decoder enable
    logic wr_en; // Write decoder enable

    // Pure decode; no state, so selects follow address and strobes at once
    always_comb begin
        rd_en = !sel.addr_hi[A15_BIT] && !sel.addr_hi[A14_BIT] && !sel.rd_n;
        wr_en = !sel.addr_hi[A15_BIT] && sel.addr_hi[A14_BIT] && !sel.wr_n;
        sel.rd_y_n = mcb_decode_n(rd_en, sel.addr_hi[SEL_MSB:SEL_LSB]);
        sel.wr_y_n = mcb_decode_n(wr_en, sel.addr_hi[SEL_MSB:SEL_LSB]);
    end

    // Enabled read decoder pulls exactly the addressed output low
    a_rd_dec_onehot: assert property (@(posedge i_clk) disable iff (i_srst)
        (!sel.addr_hi[7] && !sel.addr_hi[6] && !sel.rd_n) |->
        ($countones(~sel.rd_y_n) == 1 && !sel.rd_y_n[sel.addr_hi[2:0]]))
        else $error("read decoder output not one-hot");
    // Disabled decoders hold every output high
    a_dec_idle_high: assert property (@(posedge i_clk) disable iff (i_srst)
        (sel.rd_n && sel.wr_n) |-> (&sel.rd_y_n && &sel.wr_y_n))
        else $error("decoder output low while disabled");
    // Write decoder needs A14 high, A15 low and write strobe low
    a_wr_dec_enable: assert property (@(posedge i_clk) disable iff (i_srst)
        (!(&sel.wr_y_n)) |-> (sel.addr_hi[6] && !sel.addr_hi[7] && !sel.wr_n
        && !sel.wr_y_n[sel.addr_hi[2:0]]))
        else $error("write decoder enabled on wrong address");
endmodule : mcb_select_decode
